// ==== logic/mao_mac.sv ====
// multiply-accumulate datapath with one-cycle overflow pulse
// Notes on behaviour
// - input, pipeline and output registers each have their own clock
// - each stage picks clock enable and reset from four sources
// - multiplier works natively at 9, 18 and 36 bit operands
// - an overflow output shows accumulator overflow
// - unsigned: overflow when new sum is smaller than old accumulator
// - signed: two positives giving a negative sum is overflow
// - signed: two negatives giving a positive sum is overflow
// - overflow is high for one clock cycle per overflowing update, so back-to-back overflows keep it high
`timescale 1ns/10ps
module mao_mac
    import mao_pkg::*;
#(
    parameter int OPW = MAO_OPW,
    parameter int ACCW = MAO_ACCW
)
(
    // stage clocks, all edges of one shared system clock domain
    input wire logic clk,
    input wire logic clk_in_stage,
    input wire logic clk_pipe_stage,
    input wire logic clk_out_stage,
    input wire logic reset_n,
    // clock enable and reset sources
    input wire logic clk_en_source_0,
    input wire logic clk_en_source_1,
    input wire logic clk_en_source_2,
    input wire logic clk_en_source_3,
    input wire logic reset_source_0,
    input wire logic reset_source_1,
    input wire logic reset_source_2,
    input wire logic reset_source_3,
    // stage selections
    input wire mao_stage_sel_t in_sel,
    input wire mao_stage_sel_t pipe_sel,
    input wire mao_stage_sel_t out_sel,
    // operands and control
    input wire mao_operands_t operands,
    input wire logic acc_load,
    // results
    output logic [ACCW-1:0] acc_out,
    output logic overflow
);
    logic [MAO_NSRC-1:0] ce_src;
    logic [MAO_NSRC-1:0] rst_src;
    localparam int INW = $bits(mao_operands_t);
    logic [INW-1:0] in_q;
    mao_operands_t in_ops;
    logic [2*OPW-1:0] product;
    logic [2*OPW:0] pipe_d;
    logic [2*OPW:0] pipe_q;
    logic pipe_signed;
    logic [ACCW-1:0] addend;
    logic [ACCW-1:0] acc_reg;
    logic [ACCW-1:0] acc_next;
    logic acc_signed_reg;
    logic ovf_next;
    logic ovf_reg;

    assign ce_src = {clk_en_source_3, clk_en_source_2,
        clk_en_source_1, clk_en_source_0};
    assign rst_src = {reset_source_3, reset_source_2,
        reset_source_1, reset_source_0};

    // input register on its own clock
    mao_stage_reg #(.WIDTH(INW)) u_in_stage (
        .clk(clk_in_stage),
        .reset_n(reset_n),
        .ce_src(ce_src),
        .rst_src(rst_src),
        .sel(in_sel),
        .d(operands),
        .q(in_q)
    );
    assign in_ops = mao_operands_t'(in_q);

    // keep the native-width bits and re-extend them by sign or zero; padding from upstream is ignored
    function automatic logic [OPW-1:0] native_op(
        input logic [OPW-1:0] op,
        input mao_width_t w,
        input logic sgn
    );
        logic [OPW-1:0] r;
        r = op;
        unique case (w)
            MAO_WIDTH_9:
                r = sgn ? {{(OPW-MAO_W9){op[MAO_W9-1]}}, op[MAO_W9-1:0]}
                        : {{(OPW-MAO_W9){1'b0}}, op[MAO_W9-1:0]};
            MAO_WIDTH_18:
                r = sgn ? {{(OPW-MAO_W18){op[MAO_W18-1]}}, op[MAO_W18-1:0]}
                        : {{(OPW-MAO_W18){1'b0}}, op[MAO_W18-1:0]};
            default:
                r = op;
        endcase
        return r;
    endfunction

    always_comb
    begin
        logic [OPW-1:0] a;
        logic [OPW-1:0] b;
        a = native_op(in_ops.op_a, in_ops.width, in_ops.is_signed);
        b = native_op(in_ops.op_b, in_ops.width, in_ops.is_signed);
        if (in_ops.is_signed)
            product = $signed(a) * $signed(b);
        else
            product = a * b;
    end
    assign pipe_d = {in_ops.is_signed, product};

    // pipeline register on its own clock
    mao_stage_reg #(.WIDTH(2*OPW+1)) u_pipe_stage (
        .clk(clk_pipe_stage),
        .reset_n(reset_n),
        .ce_src(ce_src),
        .rst_src(rst_src),
        .sel(pipe_sel),
        .d(pipe_d),
        .q(pipe_q)
    );
    assign pipe_signed = pipe_q[2*OPW];
    // low product bits are already the sum term modulo 2**ACCW;
    // limitation: ACCW may not exceed the product width
    assign addend = pipe_q[ACCW-1:0];

    // wraps modulo 2**ACCW, never saturates
    assign acc_next = acc_load ? addend : acc_reg + addend;

    always_comb
    begin
        ovf_next = 1'b0;
        if (!acc_load)
        begin
            if (!pipe_signed)
                ovf_next = acc_next < acc_reg;
            else if (!acc_reg[ACCW-1] && !addend[ACCW-1])
                ovf_next = acc_next[ACCW-1];
            else if (acc_reg[ACCW-1] && addend[ACCW-1])
                ovf_next = !acc_next[ACCW-1];
        end
    end

    // output stage: accumulator and flag share the selected enable/reset
    always_ff @(posedge clk_out_stage or negedge reset_n)
    begin
        if (!reset_n)
        begin
            acc_reg <= '0;
            acc_signed_reg <= 1'b0;
        end
        else if (rst_src[out_sel.rst_sel])
        begin
            acc_reg <= '0;
            acc_signed_reg <= 1'b0;
        end
        else if (ce_src[out_sel.ce_sel])
        begin
            acc_reg <= acc_next;
            acc_signed_reg <= pipe_signed;
        end
    end

    // pulse only for the update cycle, so a held stage cannot stretch it
    always_ff @(posedge clk_out_stage or negedge reset_n)
    begin
        if (!reset_n)
            ovf_reg <= 1'b0;
        else if (rst_src[out_sel.rst_sel])
            ovf_reg <= 1'b0;
        else
            ovf_reg <= ce_src[out_sel.ce_sel] && ovf_next;
    end

    assign acc_out = acc_reg;
    assign overflow = ovf_reg;

    logic upd;
    assign upd = !rst_src[out_sel.rst_sel] && ce_src[out_sel.ce_sel]
        && !acc_load;

    a_ovf_unsigned: assert property (@(posedge clk_out_stage)
        disable iff (!reset_n)
        upd && !pipe_signed |=>
            overflow == (acc_reg < $past(acc_reg)))
        else $error("unsigned overflow mismatch");
    a_ovf_pos_pos: assert property (@(posedge clk_out_stage)
        disable iff (!reset_n)
        upd && pipe_signed && !acc_reg[ACCW-1] && !addend[ACCW-1]
            && acc_next[ACCW-1] |=> overflow)
        else $error("positive sum wrap not flagged");
    a_ovf_neg_neg: assert property (@(posedge clk_out_stage)
        disable iff (!reset_n)
        upd && pipe_signed && acc_reg[ACCW-1] && addend[ACCW-1]
            && !acc_next[ACCW-1] |=> overflow)
        else $error("negative sum wrap not flagged");
    a_ovf_mixed: assert property (@(posedge clk_out_stage)
        disable iff (!reset_n)
        upd && pipe_signed && (acc_reg[ACCW-1] != addend[ACCW-1])
            |=> !overflow)
        else $error("mixed-sign add flagged");
    a_ovf_one_cycle: assert property (@(posedge clk_out_stage)
        disable iff (!reset_n)
        overflow && !$past(upd, 1) |-> 1'b0)
        else $error("overflow without an update");
    a_acc_wraps: assert property (@(posedge clk_out_stage)
        disable iff (!reset_n)
        upd |=> acc_reg == $past(acc_reg) + $past(addend))
        else $error("accumulator did not wrap-add");
    a_acc_hold: assert property (@(posedge clk_out_stage)
        disable iff (!reset_n)
        !rst_src[out_sel.rst_sel] && !ce_src[out_sel.ce_sel]
            |=> $stable(acc_reg) && !overflow)
        else $error("output stage moved without enable");
    a_out_reset: assert property (@(posedge clk_out_stage)
        disable iff (!reset_n)
        rst_src[out_sel.rst_sel] |=> acc_reg == '0 && !overflow)
        else $error("output reset source ignored");

    c_ovf_unsigned: cover property (@(posedge clk_out_stage)
        disable iff (!reset_n) overflow && !acc_signed_reg);
    c_ovf_signed: cover property (@(posedge clk_out_stage)
        disable iff (!reset_n) overflow && acc_signed_reg);
    c_ovf_twice: cover property (@(posedge clk_out_stage)
        disable iff (!reset_n) overflow ##1 !overflow ##1 overflow);
    c_load: cover property (@(posedge clk_out_stage)
        disable iff (!reset_n) acc_load && upd == 1'b0
            && ce_src[out_sel.ce_sel]);
endmodule

// ==== logic/mao_pkg.sv ====
// package: widths, selector encodings and reset values for the mac block
package mao_pkg;
    localparam int MAO_W9 = 9;
    localparam int MAO_W18 = 18;
    localparam int MAO_W36 = 36;
    localparam int MAO_OPW = MAO_W36;
    localparam int MAO_ACCW = 52;
    localparam int MAO_NSRC = 4;
    localparam int MAO_SELW = 2;
    localparam logic [MAO_SELW-1:0] MAO_SEL_RST = 2'h0;

    typedef enum logic [1:0] {MAO_WIDTH_9, MAO_WIDTH_18, MAO_WIDTH_36}
        mao_width_t;

    // per-stage selection of clock enable and reset source
    typedef struct packed {
        logic [MAO_SELW-1:0] ce_sel;
        logic [MAO_SELW-1:0] rst_sel;
    } mao_stage_sel_t;

    typedef struct packed {
        logic [MAO_OPW-1:0] op_a;
        logic [MAO_OPW-1:0] op_b;
        logic is_signed;
        mao_width_t width;
    } mao_operands_t;
endpackage

// ==== logic/mao_stage_reg.sv ====
// pipeline register with selectable clock enable and synchronous reset
`timescale 1ns/10ps
module mao_stage_reg
    import mao_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // source selection
    input wire logic [MAO_NSRC-1:0] ce_src,
    input wire logic [MAO_NSRC-1:0] rst_src,
    input wire mao_stage_sel_t sel,
    // data
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] q_reg;

    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            q_reg <= '0;
        else if (rst_src[sel.rst_sel])
            q_reg <= '0;
        else if (ce_src[sel.ce_sel])
            q_reg <= d;
    end

    assign q = q_reg;

    a_stage_hold: assert property (@(posedge clk) disable iff (!reset_n)
        !rst_src[sel.rst_sel] && !ce_src[sel.ce_sel] |=> $stable(q_reg))
        else $error("stage register changed without enable");
    a_stage_reset: assert property (@(posedge clk) disable iff (!reset_n)
        rst_src[sel.rst_sel] |=> q_reg == '0)
        else $error("stage register not cleared by reset source");
endmodule

// ==== sim/mao_fabric_model.sv ====
// fabric-side model: pads narrow operands and counts overflow pulses
`timescale 1ns/10ps
module mao_fabric_model
    import mao_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // narrow operand in, padded operand out
    input wire logic [MAO_OPW-1:0] raw,
    input wire logic [5:0] nbits,
    input wire logic sgn,
    output logic [MAO_OPW-1:0] padded,
    // overflow pulse counting
    input wire logic overflow,
    output logic [7:0] ovf_count
);
    always_comb
    begin
        padded = raw;
        for (int i = 0; i < MAO_OPW; i++)
        begin
            if (i >= nbits)
            begin
                padded[i] = sgn & raw[nbits-1];
            end
        end
    end

    // extends the sum by one count per wrap
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            ovf_count <= 8'h00;
        else if (overflow)
            ovf_count <= ovf_count + 8'h01;
    end
endmodule

// ==== sim/testbench.sv ====
// testbench for the mac datapath with fabric-side model
`timescale 1ns/10ps
module testbench;
    import mao_pkg::*;
    logic clk, reset_n, acc_load, sg, overflow;
    logic [3:0] ce_src, rst_src;
    mao_stage_sel_t in_sel, pipe_sel, out_sel;
    mao_operands_t operands;
    mao_width_t wd;
    logic [35:0] raw_a, raw_b, pad_a, pad_b;
    logic [5:0] nb;
    logic [51:0] acc_out, exp_acc;
    logic [7:0] cnt, n_ovf;
    int n_fail, n_tests;
    assign operands = {pad_a, pad_b, sg, wd};

    mao_mac mao_mac_inst (.clk(clk), .clk_in_stage(clk),
        .clk_pipe_stage(clk), .clk_out_stage(clk), .reset_n(reset_n),
        .clk_en_source_0(ce_src[0]), .clk_en_source_1(ce_src[1]),
        .clk_en_source_2(ce_src[2]), .clk_en_source_3(ce_src[3]),
        .reset_source_0(rst_src[0]), .reset_source_1(rst_src[1]),
        .reset_source_2(rst_src[2]), .reset_source_3(rst_src[3]),
        .in_sel(in_sel), .pipe_sel(pipe_sel), .out_sel(out_sel),
        .operands(operands), .acc_load(acc_load), .acc_out(acc_out),
        .overflow(overflow));
    mao_fabric_model mao_fabric_model_inst (.clk(clk), .reset_n(reset_n),
        .raw(raw_a), .nbits(nb), .sgn(sg), .padded(pad_a),
        .overflow(overflow), .ovf_count(cnt));
    mao_fabric_model mao_fabric_model_b_inst (.clk(clk),
        .reset_n(reset_n), .raw(raw_b), .nbits(nb), .sgn(sg),
        .padded(pad_b), .overflow(1'b0), .ovf_count());

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task chk(input string nm, input logic [51:0] e, input logic [51:0] g);
        n_tests++;
        if (g !== e)
        begin
            $display("wrong value %s expected %h seen %h", nm, e, g);
            n_fail++;
        end
    endtask

    // one product through all three stages, then zeros behind it
    task automatic op(input logic [35:0] a, input logic [35:0] b,
        input logic [5:0] n, input logic s, input mao_width_t w,
        input logic ld, input logic [51:0] p);
        logic [51:0] old;
        logic e;
        old = exp_acc;
        exp_acc = ld ? p : old + p;
        e = !ld && (s ? (old[51] == p[51] && exp_acc[51] != old[51])
            : exp_acc < old);
        @(posedge clk);
        raw_a <= a;
        raw_b <= b;
        nb <= n;
        sg <= s;
        wd <= w;
        @(posedge clk);
        raw_a <= 36'h0;
        raw_b <= 36'h0;
        @(posedge clk);
        // load is taken by the output stage together with the product
        acc_load <= ld;
        @(posedge clk);
        acc_load <= 1'b0;
        #1;
        chk("acc_out", exp_acc, acc_out);
        chk("overflow", {51'h0, e}, {51'h0, overflow});
        @(posedge clk);
        #1;
        chk("overflow", 52'h0, {51'h0, overflow});
        n_ovf = n_ovf + {7'h0, e};
    endtask

    task t_widths;
        for (int i = 0; i < 3; i++)
        begin
            op(36'hA, 36'h5, 6'h4, 1, mao_width_t'(i), 1,
                52'hFFFFFFFFFFFE2);
            op(36'h1FF, 36'h2, 6'h9, 0, mao_width_t'(i), 1,
                52'h3FE);
        end
        $display("test widths done");
    endtask

    task t_wraps;
        op(36'h800000000, 36'h10000, 6'h24, 0, MAO_WIDTH_36, 1,
            52'h8000000000000);
        op(36'h800000000, 36'h10000, 6'h24, 0, MAO_WIDTH_36, 0,
            52'h8000000000000);
        op(36'h3, 36'h1, 6'h24, 0, MAO_WIDTH_36, 0, 52'h3);
        op(36'h400000000, 36'h10000, 6'h24, 1, MAO_WIDTH_36, 1,
            52'h4000000000000);
        op(36'h400000000, 36'h10000, 6'h24, 1, MAO_WIDTH_36, 0,
            52'h4000000000000);
        op(36'h800000000, 36'h10000, 6'h24, 1, MAO_WIDTH_36, 1,
            52'h8000000000000);
        for (int i = 0; i < 2; i++)
            op(36'hFFFFFFFFF, 36'h1, 6'h24, 1, MAO_WIDTH_36, 0,
                52'hFFFFFFFFFFFFF);
        chk("ovf_count", {44'h0, n_ovf}, {44'h0, cnt});
        $display("test wraps done");
    endtask

    // each source index steers the input enable and output reset
    task t_stages;
        for (int i = 0; i < 4; i++)
        begin
            op(36'h5, 36'h5, 6'h24, 0, MAO_WIDTH_36, 1, 52'h19);
            @(posedge clk);
            // later stages on another source, so only the input holds
            in_sel.ce_sel <= i[1:0];
            pipe_sel.ce_sel <= i[1:0] + 2'h1;
            out_sel.ce_sel <= i[1:0] + 2'h1;
            ce_src[i] <= 1'b0;
            op(36'h7, 36'h7, 6'h24, 0, MAO_WIDTH_36, 0, 52'h0);
            @(posedge clk);
            ce_src[i] <= 1'b1;
            in_sel <= '0;
            pipe_sel <= '0;
            out_sel <= {2'h0, i[1:0]};
            rst_src[i] <= 1'b1;
            @(posedge clk);
            rst_src[i] <= 1'b0;
            out_sel <= '0;
            #1;
            exp_acc = 52'h0;
            chk("acc_out", exp_acc, acc_out);
        end
        $display("test stages done");
    endtask

    task final_report;
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        #20000;
        n_fail++;
        final_report;
    end

    initial
    begin
        {reset_n, acc_load, sg, raw_a, raw_b, rst_src} = '0;
        {in_sel, pipe_sel, out_sel} = '0;
        ce_src = 4'hF;
        nb = 6'h24;
        wd = MAO_WIDTH_36;
        exp_acc = 52'h0;
        n_ovf = 8'h00;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk("acc_out", 52'h0, acc_out);
        t_widths;
        t_wraps;
        t_stages;
        final_report;
    end
endmodule
